// file: wsb_pkg.sv
package wsb_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_BAUD     = 8'h04;
	localparam logic [7:0] OFS_PIN_OUT  = 8'h08;
	localparam logic [7:0] OFS_PIN_IN   = 8'h0c;
	localparam logic [7:0] OFS_PIN_AUX  = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_BLANK_LSB = 8;
	localparam int CTRL_CHAN_LSB  = 16;

	localparam logic [1:0] MODE_AUTO       = 2'h0;
	localparam logic [1:0] MODE_USB_RADIO  = 2'h1;
	localparam logic [1:0] MODE_UART_RADIO = 2'h2;
	localparam logic [1:0] MODE_USB_UART   = 2'h3;

	localparam logic [7:0]  RST_BLANK_MS = 8'h00;
	localparam logic [7:0]  RST_CHANNEL  = 8'h80;
	localparam logic [7:0]  PIN_NONE     = 8'hff;
	// Pin codes are port * 10 + bit: 10, 11, 12, 13 and 0.
	localparam logic [31:0] RST_PIN_OUT  = {PIN_NONE, PIN_NONE, 8'h0b, 8'h0a};
	localparam logic [31:0] RST_PIN_IN   = {PIN_NONE, PIN_NONE, 8'h0d, 8'h0c};
	localparam logic [7:0]  RST_PIN_AUX  = 8'h00;
	localparam int          PIN_PORT_MUL = 10;
	localparam int          GPIO_W       = 24;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int MS_NS          = 1000000;
	localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
	localparam int BAUD_HZ        = 9600;
	localparam int CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
	localparam logic [15:0] RST_BAUD_DIV = 16'(CLK_HZ / BAUD_HZ);
	localparam logic [9:0] GREEN_MS    = 10'd20;
	localparam logic [9:0] RED_MS      = 10'd50;
	localparam logic [9:0] FLICK_MS    = 10'd20;
	localparam logic [9:0] BLINK_MS    = 10'd50;
	localparam logic [9:0] SLOW_MS     = 10'd500;
	localparam logic [9:0] SECOND_MS   = 10'd999;
	localparam logic [3:0] UART_BITS   = 4'd8;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} wsb_apb_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} wsb_byte_t;

endpackage : wsb_pkg

// file: wsb_bridge.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module wsb_bridge #(
	parameter int MS_CYCLES = wsb_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	// APB slave
	input  wire wsb_pkg::wsb_apb_req_t apb_req,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Power sensing
	input  wire logic                  usb_present,
	input  wire logic                  external_supply_present,
	// USB virtual COM port
	input  wire wsb_pkg::wsb_byte_t    usb_rx,
	output logic                       usb_rx_ready,
	output wsb_pkg::wsb_byte_t         usb_tx,
	input  wire logic                  usb_tx_ready,
	input  wire logic                  usb_dtr,
	input  wire logic                  usb_rts,
	output logic                       usb_dsr,
	output logic                       usb_cd,
	// Radio link
	output wsb_pkg::wsb_byte_t         rf_tx,
	input  wire logic                  rf_tx_ready,
	output logic [1:0]                 rf_tx_ctrl,
	input  wire wsb_pkg::wsb_byte_t    rf_rx,
	output logic                       rf_rx_ready,
	input  wire logic [1:0]            rf_rx_ctrl,
	input  wire logic                  rf_packet_busy,
	output logic [7:0]                 rf_channel,
	output logic                       rf_tx_active_n,
	// UART
	input  wire logic                  uart_rx,
	output logic                       uart_tx,
	// General purpose pins
	input  wire logic [23:0]           gpio_in,
	output logic [23:0]                gpio_out,
	output logic [23:0]                gpio_oe,
	// Indicators
	output logic                       led_green,
	output logic                       led_yellow,
	output logic                       led_red
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] pin_index(input logic [7:0] code);
		logic [7:0] port;
		logic [7:0] bitn;
		port = code / 8'(wsb_pkg::PIN_PORT_MUL);
		bitn = code % 8'(wsb_pkg::PIN_PORT_MUL);
		if (code == wsb_pkg::PIN_NONE || bitn > 8'd7 || port > 8'd2)
			pin_index = 6'h3f;
		else
			pin_index = {port[2:0], bitn[2:0]};
	endfunction : pin_index

	function automatic logic pin_read(input logic [7:0] code, input logic [23:0] pins);
		logic [5:0] idx;
		idx = pin_index(code);
		pin_read = (idx == 6'h3f) ? 1'b0 : pins[idx[4:0]];
	endfunction : pin_read

	function automatic logic pin_level(input logic [7:0] code, input logic inv,
		input logic [23:0] pins);
		// A disabled pin reads as logical 0 whatever its polarity.
		pin_level = (pin_index(code) != 6'h3f) && (pin_read(code, pins) ^ inv);
	endfunction : pin_level

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [15:0] baud_div_q;
	logic [31:0] pin_out_q;
	logic [31:0] pin_in_q;
	logic [7:0]  pin_aux_q;
	logic        wr_en;
	logic        hit;
	logic [1:0]  mode_q;
	logic        contact_q;
	logic        ferr_q;
	logic        blank_q;

	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		hit = 1'b1;
		unique case (apb_req.paddr)
			wsb_pkg::OFS_CTRL:    prdata = ctrl_q;
			wsb_pkg::OFS_BAUD:    prdata = {16'h0000, baud_div_q};
			wsb_pkg::OFS_PIN_OUT: prdata = pin_out_q;
			wsb_pkg::OFS_PIN_IN:  prdata = pin_in_q;
			wsb_pkg::OFS_PIN_AUX: prdata = {24'h000000, pin_aux_q};
			wsb_pkg::OFS_STATUS:  prdata = {27'h0, blank_q, ferr_q, contact_q, mode_q};
			default:
			begin
				prdata = 32'h00000000;
				hit = 1'b0;
			end
		endcase
	end

	assign pslverr = apb_req.psel && apb_req.penable && !hit;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q     <= {8'h00, wsb_pkg::RST_CHANNEL, wsb_pkg::RST_BLANK_MS,
				6'h00, wsb_pkg::MODE_AUTO};
			baud_div_q <= wsb_pkg::RST_BAUD_DIV;
			pin_out_q  <= wsb_pkg::RST_PIN_OUT;
			pin_in_q   <= wsb_pkg::RST_PIN_IN;
			pin_aux_q  <= wsb_pkg::RST_PIN_AUX;
		end
		else if (wr_en)
		begin
			unique case (apb_req.paddr)
				wsb_pkg::OFS_CTRL:    ctrl_q <= {8'h00, apb_req.pwdata[23:8], 6'h00,
					apb_req.pwdata[1:0]};
				wsb_pkg::OFS_BAUD:    baud_div_q <= apb_req.pwdata[15:0];
				wsb_pkg::OFS_PIN_OUT: pin_out_q <= apb_req.pwdata;
				wsb_pkg::OFS_PIN_IN:  pin_in_q <= apb_req.pwdata;
				wsb_pkg::OFS_PIN_AUX: pin_aux_q <= apb_req.pwdata[7:0];
				default:              ;
			endcase
		end
	end

	assign rf_channel = ctrl_q[wsb_pkg::CTRL_CHAN_LSB +: 8];

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	logic [1:0] cfg_mode;
	logic [1:0] auto_mode;
	assign cfg_mode = ctrl_q[wsb_pkg::CTRL_MODE_LSB +: 2];
	assign auto_mode = (usb_present && external_supply_present) ? wsb_pkg::MODE_USB_UART :
		(external_supply_present ? wsb_pkg::MODE_UART_RADIO : wsb_pkg::MODE_USB_RADIO);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			mode_q <= wsb_pkg::MODE_USB_RADIO;
		else
			mode_q <= (cfg_mode == wsb_pkg::MODE_AUTO) ? auto_mode : cfg_mode;
	end

	logic m_ur;
	logic m_ar;
	logic m_uu;
	assign m_ur = (mode_q == wsb_pkg::MODE_USB_RADIO);
	assign m_ar = (mode_q == wsb_pkg::MODE_UART_RADIO);
	assign m_uu = (mode_q == wsb_pkg::MODE_USB_UART);

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	logic [15:0] ms_cnt_q;
	logic        ms_tick;
	assign ms_tick = (ms_cnt_q == 16'(MS_CYCLES - 1));
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ms_cnt_q <= 16'h0000;
		else
			ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
	end

	// ----------------------------------------------------------------
	// UART receiver
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		WSB_RX_IDLE  = 4'b0001,
		WSB_RX_START = 4'b0010,
		WSB_RX_DATA  = 4'b0100,
		WSB_RX_STOP  = 4'b1000
	} wsb_rx_state_t;

	wsb_rx_state_t rx_st_q;
	logic [15:0]   rx_cnt_q;
	logic [3:0]    rx_bit_q;
	logic [7:0]    rx_sh_q;
	logic          rx_done;
	logic          rx_ferr;
	logic [7:0]    blank_ms_q;
	logic          rx_mid;
	assign rx_mid = (rx_cnt_q == 16'h0000);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_st_q  <= WSB_RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 8'h00;
		end
		else
		begin
			rx_cnt_q <= rx_mid ? baud_div_q - 16'h0001 : rx_cnt_q - 16'h0001;
			unique case (rx_st_q)
				WSB_RX_IDLE:
					if (!uart_rx && !blank_q && !ferr_q)
					begin
						rx_st_q  <= WSB_RX_START;
						rx_cnt_q <= {1'b0, baud_div_q[15:1]};
					end
				WSB_RX_START:
					if (rx_mid)
					begin
						rx_st_q  <= uart_rx ? WSB_RX_IDLE : WSB_RX_DATA;
						rx_bit_q <= 4'h0;
					end
				WSB_RX_DATA:
					if (rx_mid)
					begin
						rx_sh_q  <= {uart_rx, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == wsb_pkg::UART_BITS - 4'h1)
							rx_st_q <= WSB_RX_STOP;
					end
				WSB_RX_STOP:
					if (rx_mid)
						rx_st_q <= WSB_RX_IDLE;
				default: rx_st_q <= WSB_RX_IDLE;
			endcase
		end
	end

	assign rx_done = (rx_st_q == WSB_RX_STOP) && rx_mid && uart_rx;
	assign rx_ferr = (rx_st_q == WSB_RX_STOP) && rx_mid && !uart_rx;

	// A framing error holds the receiver off until the line idles high, and the
	// blanking time runs from the error, so a broken stream cannot re-trigger.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ferr_q     <= 1'b0;
			blank_q    <= 1'b0;
			blank_ms_q <= 8'h00;
		end
		else if (rx_ferr)
		begin
			ferr_q     <= 1'b1;
			blank_q    <= (ctrl_q[wsb_pkg::CTRL_BLANK_LSB +: 8] != 8'h00);
			blank_ms_q <= ctrl_q[wsb_pkg::CTRL_BLANK_LSB +: 8];
		end
		else
		begin
			if (uart_rx)
				ferr_q <= 1'b0;
			if (blank_q && ms_tick)
			begin
				blank_ms_q <= blank_ms_q - 8'h01;
				blank_q    <= (blank_ms_q != 8'h01);
			end
		end
	end

	// ----------------------------------------------------------------
	// Routing holders
	// ----------------------------------------------------------------
	logic       utx_v_q;
	logic [7:0] utx_d_q;
	logic       utx_take;
	logic       usb_in_hs;
	logic       rf_in_hs;
	logic       drop;

	assign usb_rx_ready = m_ur ? !rf_tx.valid : (m_uu ? !utx_v_q : 1'b0);
	assign rf_rx_ready  = m_ur ? !usb_tx.valid : (m_ar ? !utx_v_q : 1'b0);
	assign usb_in_hs = usb_rx.valid && usb_rx_ready;
	assign rf_in_hs  = rf_rx.valid && rf_rx_ready;
	assign drop = rx_done && ((m_ar && rf_tx.valid) || (m_uu && usb_tx.valid));

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rf_tx  <= '0;
			usb_tx <= '0;
		end
		else
		begin
			if (rf_tx.valid && rf_tx_ready)
				rf_tx.valid <= 1'b0;
			else if (m_ur && usb_in_hs)
				rf_tx <= usb_rx;
			else if (m_ar && rx_done)
				rf_tx <= '{valid: 1'b1, data: rx_sh_q};
			if (usb_tx.valid && usb_tx_ready)
				usb_tx.valid <= 1'b0;
			else if (m_ur && rf_in_hs)
				usb_tx <= rf_rx;
			else if (m_uu && rx_done)
				usb_tx <= '{valid: 1'b1, data: rx_sh_q};
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			utx_v_q <= 1'b0;
			utx_d_q <= 8'h00;
		end
		else if (utx_take)
			utx_v_q <= 1'b0;
		else if ((m_ar && rf_in_hs) || (m_uu && usb_in_hs))
		begin
			utx_v_q <= 1'b1;
			utx_d_q <= m_ar ? rf_rx.data : usb_rx.data;
		end
	end

	// ----------------------------------------------------------------
	// UART transmitter
	// ----------------------------------------------------------------
	logic [9:0]  tx_sh_q;
	logic [3:0]  tx_left_q;
	logic [15:0] tx_cnt_q;
	assign utx_take = utx_v_q && (tx_left_q == 4'h0);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_sh_q   <= 10'h3ff;
			tx_left_q <= 4'h0;
			tx_cnt_q  <= 16'h0000;
		end
		else if (utx_take)
		begin
			tx_sh_q   <= {1'b1, utx_d_q, 1'b0};
			tx_left_q <= 4'd10;
			tx_cnt_q  <= baud_div_q - 16'h0001;
		end
		else if (tx_left_q != 4'h0)
		begin
			if (tx_cnt_q == 16'h0000)
			begin
				tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
				tx_left_q <= tx_left_q - 4'h1;
				tx_cnt_q  <= baud_div_q - 16'h0001;
			end
			else
				tx_cnt_q <= tx_cnt_q - 16'h0001;
		end
	end

	assign uart_tx = tx_sh_q[0];

	// ----------------------------------------------------------------
	// Control signals and pins
	// ----------------------------------------------------------------
	logic dsr_pin;
	logic true_in_b_pin;
	logic dtr_log;
	logic rts_log;
	assign dsr_pin = pin_level(pin_in_q[7:0], 1'b1, gpio_in)
		|| pin_level(pin_in_q[23:16], 1'b0, gpio_in);
	assign true_in_b_pin  = pin_level(pin_in_q[15:8], 1'b1, gpio_in)
		|| pin_level(pin_in_q[31:24], 1'b0, gpio_in);
	assign dtr_log = m_ar ? rf_rx_ctrl[0] : usb_dtr;
	assign rts_log = m_ar ? rf_rx_ctrl[1] : usb_rts;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rf_tx_ctrl <= 2'b00;
			usb_dsr    <= 1'b0;
			usb_cd     <= 1'b0;
		end
		else
		begin
			rf_tx_ctrl <= m_ar ? {true_in_b_pin, dsr_pin} : {usb_rts, usb_dtr};
			usb_dsr    <= m_ur ? rf_rx_ctrl[0] : dsr_pin;
			usb_cd     <= m_ur ? rf_rx_ctrl[1] : true_in_b_pin;
		end
	end

	// Outputs only change in a mode that owns the pins; USB-radio leaves them idle.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gpio_out <= '0;
			gpio_oe  <= '0;
		end
		else
		begin
			for (int i = 0; i < wsb_pkg::GPIO_W; i++)
			begin
				gpio_oe[i]  <= 1'b0;
				gpio_out[i] <= 1'b0;
				if (pin_index(pin_out_q[7:0]) == 6'(i))
				begin
					gpio_oe[i]  <= 1'b1;
					gpio_out[i] <= !(dtr_log && !m_ur);
				end
				if (pin_index(pin_out_q[15:8]) == 6'(i))
				begin
					gpio_oe[i]  <= 1'b1;
					gpio_out[i] <= !(rts_log && !m_ur);
				end
				if (pin_index(pin_out_q[23:16]) == 6'(i))
				begin
					gpio_oe[i]  <= 1'b1;
					gpio_out[i] <= dtr_log && !m_ur;
				end
				if (pin_index(pin_out_q[31:24]) == 6'(i))
				begin
					gpio_oe[i]  <= 1'b1;
					gpio_out[i] <= rts_log && !m_ur;
				end
				if (pin_index(pin_aux_q) == 6'(i))
				begin
					gpio_oe[i]  <= 1'b1;
					gpio_out[i] <= !(dtr_log && !m_ur);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	logic [9:0] green_q;
	logic [9:0] red_q;
	logic [9:0] flick_q;
	logic [9:0] sec_q;
	logic       slow_q;
	logic       rf_act;
	assign rf_act = rf_in_hs || (rf_tx.valid && rf_tx_ready);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			green_q   <= 10'h000;
			red_q     <= 10'h000;
			flick_q   <= 10'h000;
			sec_q     <= 10'h000;
			slow_q    <= 1'b0;
			contact_q <= 1'b0;
		end
		else
		begin
			if (usb_in_hs || (usb_tx.valid && usb_tx_ready))
				green_q <= wsb_pkg::GREEN_MS;
			else if (ms_tick && green_q != 10'h000)
				green_q <= green_q - 10'h001;
			if (drop)
				red_q <= wsb_pkg::RED_MS;
			else if (ms_tick && red_q != 10'h000)
				red_q <= red_q - 10'h001;
			if (rf_act)
				flick_q <= wsb_pkg::FLICK_MS;
			else if (ms_tick && flick_q != 10'h000)
				flick_q <= flick_q - 10'h001;
			if (rf_rx.valid && rf_rx_ready)
				contact_q <= 1'b1;
			if (ms_tick)
			begin
				sec_q <= (sec_q == wsb_pkg::SECOND_MS) ? 10'h000 : sec_q + 10'h001;
				if (sec_q == wsb_pkg::SLOW_MS - 10'h001 || sec_q == wsb_pkg::SECOND_MS)
					slow_q <= !slow_q;
			end
		end
	end

	assign led_green  = (green_q != 10'h000);
	assign led_red    = ferr_q || (red_q != 10'h000);
	assign led_yellow = !m_uu && (contact_q ?
		((sec_q < wsb_pkg::BLINK_MS) ^ (flick_q != 10'h000)) : slow_q);

	// The radio reports its packet time; one flop keeps the pin glitch free.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rf_tx_active_n <= 1'b1;
		else
			rf_tx_active_n <= !rf_packet_busy;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_MODE_FORCED: assert property (cfg_mode != 2'h0 |=> mode_q == $past(cfg_mode))
		else $error("forced mode not applied");
	AST_AUTO_BOTH: assert property (cfg_mode == 2'h0 && usb_present && external_supply_present
		|=> mode_q == 2'h3)
		else $error("auto mode with both supplies wrong");
	AST_USB_TO_RF: assert property (m_ur && usb_in_hs |=> rf_tx.valid
		&& rf_tx.data == $past(usb_rx.data))
		else $error("usb byte not forwarded to radio");
	AST_RF_TO_UART: assert property (m_ar && rf_in_hs && !utx_take |=> utx_v_q
		&& utx_d_q == $past(rf_rx.data))
		else $error("radio byte not queued to uart");
	AST_USB_TO_UART: assert property (m_uu && usb_in_hs |-> !rf_rx_ready ##1 utx_v_q)
		else $error("usb byte not queued to uart");
	AST_TX_ACTIVE: assert property (rf_packet_busy |=> !rf_tx_active_n)
		else $error("debug output not low during packet");
	AST_UART_START: assert property (utx_take |=> !uart_tx [*1] ##1 tx_left_q == 4'd10
		|| tx_left_q == 4'd9)
		else $error("start bit missing");
	AST_GREEN: assert property (usb_in_hs |=> led_green [*2])
		else $error("green not pulsed on usb data");
	AST_YELLOW_OFF: assert property (m_uu |-> !led_yellow)
		else $error("yellow lit without radio");
	AST_DROP_RED: assert property (drop |=> led_red)
		else $error("drop did not flash red");
	AST_FERR_RED: assert property (rx_ferr ##1 !uart_rx |-> led_red)
		else $error("red not held after framing error");
	AST_CTRL_USB_RF: assert property (m_ur && $stable(mode_q) |=> rf_tx_ctrl
		== $past({usb_rts, usb_dtr}))
		else $error("usb controls not sent over radio");

	COV_DROP: cover property (drop);
	COV_FERR: cover property (rx_ferr ##[1:20] uart_rx);
	COV_AUTO_SWITCH: cover property (m_ur ##1 m_uu);

endmodule : wsb_bridge

`default_nettype wire

// file: wsb_far.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Far side: radio peer and USB host
// ----------------------------------------------------------------
module wsb_far (
	// Clock
	input  wire logic               clock,
	// Byte streams from the bridge
	input  wire wsb_pkg::wsb_byte_t rf_tx,
	input  wire wsb_pkg::wsb_byte_t usb_tx,
	output logic                    rf_tx_ready,
	output logic                    usb_tx_ready,
	output logic                    rf_packet_busy,
	// Last bytes taken, for the bench
	output logic [7:0]              rf_last,
	output logic [7:0]              usb_last
);
	logic [2:0] tick_q = 3'h0;
	logic [2:0] busy_q = 3'h0;

	// The radio stalls on alternate cycles, so the bridge must hold its byte.
	assign rf_tx_ready    = tick_q[0];
	assign usb_tx_ready   = 1'b1;
	assign rf_packet_busy = busy_q != 3'h0;

	always_ff @(posedge clock)
	begin
		tick_q <= tick_q + 3'h1;
		if (rf_tx.valid && rf_tx_ready)
		begin
			rf_last <= rf_tx.data;
			busy_q  <= 3'h5;
		end
		else if (busy_q != 3'h0)
			busy_q <= busy_q - 3'h1;
		if (usb_tx.valid && usb_tx_ready)
			usb_last <= usb_tx.data;
	end
endmodule : wsb_far

`default_nettype wire

// file: test_wsb_bridge.sv
`timescale 1ns/100ps
`default_nettype none

module test_wsb_bridge;
	logic clock = 1'b0, reset_n = 1'b0, usb_present = 1'b0, ext_pwr = 1'b0;
	logic usb_dtr = 1'b0, usb_rts = 1'b0, uart_rx = 1'b1, rf_tx_ready, usb_tx_ready;
	logic rf_packet_busy, usb_rx_ready, rf_rx_ready, usb_dsr, usb_cd, uart_tx;
	logic pready, pslverr, e, rf_tx_active_n, led_green, led_yellow, led_red;
	logic [1:0] rf_rx_ctrl = 2'h0, rf_tx_ctrl;
	logic [7:0] rf_channel, rf_last, usb_last, b;
	logic [31:0] prdata, q;
	logic [23:0] gpio_in = 24'hffffff, gpio_out, gpio_oe;
	wsb_pkg::wsb_apb_req_t req = '0;
	wsb_pkg::wsb_byte_t usb_rx = '0, rf_rx = '0, usb_tx, rf_tx;
	int errors = 0, checked = 0, n;

	wsb_bridge #(.MS_CYCLES(20)) i_wsb_bridge (.clock(clock), .reset_n(reset_n),
		.apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_present(usb_present), .external_supply_present(ext_pwr),
		.usb_rx(usb_rx), .usb_rx_ready(usb_rx_ready), .usb_tx(usb_tx),
		.usb_tx_ready(usb_tx_ready), .usb_dtr(usb_dtr), .usb_rts(usb_rts),
		.usb_dsr(usb_dsr), .usb_cd(usb_cd), .rf_tx(rf_tx), .rf_tx_ready(rf_tx_ready),
		.rf_tx_ctrl(rf_tx_ctrl), .rf_rx(rf_rx), .rf_rx_ready(rf_rx_ready),
		.rf_rx_ctrl(rf_rx_ctrl), .rf_packet_busy(rf_packet_busy), .rf_channel(rf_channel),
		.rf_tx_active_n(rf_tx_active_n), .uart_rx(uart_rx), .uart_tx(uart_tx),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.led_green(led_green), .led_yellow(led_yellow), .led_red(led_red));

	wsb_far i_wsb_far (.clock(clock), .rf_tx(rf_tx), .usb_tx(usb_tx),
		.rf_tx_ready(rf_tx_ready), .usb_tx_ready(usb_tx_ready),
		.rf_packet_busy(rf_packet_busy), .rf_last(rf_last), .usb_last(usb_last));

	initial
	begin
		forever #50 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// A wait that used up its bound ends the run as a failure.
	task limit(input int k, input int lim);
		if (k >= lim)
		begin
			errors++;
			tally_and_finish();
		end
	endtask : limit

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		limit(n, 50);
		req <= '0;
	endtask : apb

	// Offers one byte and holds it until the bridge takes it.
	task put(input logic rf, input logic [7:0] d);
		@(posedge clock);
		if (rf)
			rf_rx <= {1'b1, d};
		else
			usb_rx <= {1'b1, d};
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while ((rf ? rf_rx_ready : usb_rx_ready) !== 1'b1 && n < 50);
		limit(n, 50);
		rf_rx <= '0;
		usb_rx <= '0;
	endtask : put

	// Serial frames at a divisor of 16 cycles per bit, LSB first.
	task uart_put(input logic [7:0] d, input logic stop);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clock);
			uart_rx <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
			repeat (15) @(posedge clock);
		end
	endtask : uart_put

	task uart_get();
		int w;
		for (w = 0; w < 2000 && uart_tx !== 1'b0; w++)
			@(posedge clock);
		limit(w, 2000);
		repeat (8) @(posedge clock);
		for (int i = 0; i < 9; i++)
		begin
			repeat (16) @(posedge clock);
			if (i < 8)
				b[i] = uart_tx;
			else
				check("stop bit", uart_tx, 1'b1);
		end
	endtask : uart_get

	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		apb(0, wsb_pkg::OFS_CTRL, 0);
		check("ctrl reset", q, 32'h00800000);
		check("channel", rf_channel, 8'h80);
		apb(0, wsb_pkg::OFS_BAUD, 0);
		check("baud reset", q, 32'h00000411);
		apb(0, wsb_pkg::OFS_PIN_OUT, 0);
		check("pin out reset", q, 32'hffff0b0a);
		apb(0, wsb_pkg::OFS_PIN_IN, 0);
		check("pin in reset", q, 32'hffff0d0c);
		apb(0, wsb_pkg::OFS_PIN_AUX, 0);
		check("pin aux reset", q, 32'h0);
		apb(0, 8'h18, 0);
		check("unmapped", {q[30:0], e}, 32'h1);
		for (int m = 1; m < 4; m++)
		begin
			usb_present <= m[0];
			ext_pwr <= m[1];
			repeat (3) @(posedge clock);
			apb(0, wsb_pkg::OFS_STATUS, 0);
			check("auto mode", q[1:0], m);
		end
		apb(1, wsb_pkg::OFS_CTRL, 32'h00800001);
		apb(0, wsb_pkg::OFS_STATUS, 0);
		check("forced mode", q[1:0], 2'h1);
		usb_dtr <= 1'b1;
		rf_rx_ctrl <= 2'b10;
		put(0, 8'ha5);
		for (n = 0; n < 50 && rf_packet_busy !== 1'b1; n++)
			@(posedge clock);
		limit(n, 50);
		repeat (2) @(posedge clock);
		check("radio busy debug", rf_tx_active_n, 1'b0);
		check("usb to radio", rf_last, 8'ha5);
		check("green", led_green, 1'b1);
		put(1, 8'h3c);
		repeat (4) @(posedge clock);
		check("radio to usb", usb_last, 8'h3c);
		check("ctrl to peer", rf_tx_ctrl, 2'b01);
		check("ctrl from peer", {usb_cd, usb_dsr}, 2'b10);
		apb(1, wsb_pkg::OFS_BAUD, 32'h10);
		apb(1, wsb_pkg::OFS_CTRL, 32'h00800003);
		gpio_in[10] <= 1'b0;
		fork
			put(0, 8'h5a);
			uart_get();
		join
		check("usb to uart", b, 8'h5a);
		uart_put(8'hc3, 1'b1);
		repeat (20) @(posedge clock);
		check("uart to usb", usb_last, 8'hc3);
		check("inverted outs", {gpio_oe[9:8], gpio_out[9:8]}, 4'hf & 4'b1110);
		check("inverted in", {usb_cd, usb_dsr}, 2'b01);
		check("yellow off", led_yellow, 1'b0);
		apb(1, wsb_pkg::OFS_CTRL, 32'h00800002);
		fork
			put(1, 8'h96);
			uart_get();
		join
		check("radio to uart", b, 8'h96);
		uart_put(8'h69, 1'b1);
		repeat (20) @(posedge clock);
		check("uart to radio", rf_last, 8'h69);
		check("pins to peer", rf_tx_ctrl, 2'b01);
		check("peer to pins", gpio_out[9:8], 2'b01);
		uart_put(8'h00, 1'b0);
		repeat (4) @(posedge clock);
		check("framing red", led_red, 1'b1);
		uart_rx <= 1'b1;
		tally_and_finish();
	end

	initial
	begin
		#5ms;
		errors++;
		tally_and_finish();
	end
endmodule : test_wsb_bridge

`default_nettype wire
